// [verilog/cbd_cpu_end.sv]
// Summary of operation
// - Data path is 64 shared active-low lines
// - Driver strobes data-valid on every valid word
// - Driver may idle strobe; capture only strobed words
// - Driver holds bus-occupied while using data bus
// - Start only after bus-occupied is released
// - Target asserts deferral; processor only receives
// - Check lanes driven with data by driver
// - Check enable fixed at reset release
// - Float error output asserted on unmasked error
// - Flush: write back modified, then invalidate all
// - Flush acknowledge issued after flush completes
// - No cache allocation while flush held
// - System makes flush valid by target-ready; the code ignores target-ready and starts a flush on the flush pin alone
// - Flush pin level sampled at reset release
`timescale 1ns/1ps
`include "cbd_defs.svh"
module cbd_cpu_end (
    input  wire logic        clk,
    input  wire logic        nrst,
    cbd_bus_if.cpu           bus,
    input  wire logic        dataGrant,
    input  wire logic        eccStrap,
    input  wire logic        txValid,
    input  wire logic [63:0] txData,
    input  wire logic        txLast,
    output logic             txReady,
    output logic             rxValid,
    output logic      [63:0] rxData,
    output logic             rxCheckError,
    output logic             deferred,
    input  wire logic        fpError,
    input  wire logic        fpMasked,
    input  wire logic        dirtyValid,
    input  wire logic [63:0] dirtyData,
    input  wire logic        dirtyLast,
    input  wire logic        dirtyDone,
    output logic             dirtyReady,
    output logic             invalidateAll,
    output logic             noAllocate,
    output logic             flushBusy,
    output logic             eccEnabled,
    output logic             flushStrap
);
    // ****************************************************************
    // Reset release and flush pin synchroniser
    // ****************************************************************
    logic nrstPrev;
    logic flushMeta;
    logic flushSync;
    logic flushReq;

    // No reset on the chain so it holds the true pin level at release
    always_ff @(posedge clk) begin
        flushMeta <= bus.flushN;
        flushSync <= flushMeta;
    end

    assign flushReq = (flushSync == `CBD_ON);

    always_ff @(posedge clk) begin
        nrstPrev <= nrst;
    end

    // Straps caught on the first edge after release, then frozen
    always_ff @(posedge clk) begin
        if (!nrst) begin
            eccEnabled <= 1'b0;
            flushStrap <= 1'b0;
        end else if (!nrstPrev) begin
            eccEnabled <= eccStrap;
            flushStrap <= flushReq;
        end
    end

    // ****************************************************************
    // Flush sequence
    // ****************************************************************
    cbd_pkg::cbd_flush_state_t flState;
    logic                      fifoInValid;
    logic [64:0]               fifoInData;
    logic                      fifoInReady;
    logic                      fifoOutValid;
    logic [64:0]               fifoOutData;
    logic                      fifoPop;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flState <= cbd_pkg::FL_IDLE;
        end else begin
            unique case (flState)
                cbd_pkg::FL_IDLE: begin
                    if (flushReq && nrstPrev) begin
                        flState <= cbd_pkg::FL_WB;
                    end
                end
                cbd_pkg::FL_WB: begin
                    // Wait for the queue to drain so write-backs reach the bus first
                    if (dirtyDone && !dirtyValid && !fifoOutValid) begin
                        flState <= cbd_pkg::FL_INVAL;
                    end
                end
                cbd_pkg::FL_INVAL: begin
                    flState <= cbd_pkg::FL_ACK;
                end
                cbd_pkg::FL_ACK: begin
                    flState <= cbd_pkg::FL_HOLD;
                end
                cbd_pkg::FL_HOLD: begin
                    if (!flushReq) begin
                        flState <= cbd_pkg::FL_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            invalidateAll <= 1'b0;
            bus.flushAckN <= `CBD_OFF;
            noAllocate    <= 1'b0;
        end else begin
            invalidateAll <= (flState == cbd_pkg::FL_INVAL);
            bus.flushAckN <= (flState == cbd_pkg::FL_ACK) ? `CBD_ON : `CBD_OFF;
            noAllocate    <= flushReq;
        end
    end

    assign flushBusy = (flState != cbd_pkg::FL_IDLE);

    // ****************************************************************
    // Outgoing queue: user writes, or modified lines during a flush
    // ****************************************************************
    always_comb begin
        if (flState == cbd_pkg::FL_WB) begin
            fifoInValid = dirtyValid;
            fifoInData  = {dirtyLast, dirtyData};
        end else begin
            fifoInValid = txValid & ~flushBusy;
            fifoInData  = {txLast, txData};
        end
    end

    assign dirtyReady = fifoInReady & (flState == cbd_pkg::FL_WB);
    assign txReady    = fifoInReady & ~flushBusy;

    cbd_fifo #(
        .WIDTH (`CBD_FIFO_W),
        .DEPTH (`CBD_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .nrst     (nrst),
        .inValid  (fifoInValid),
        .inData   (fifoInData),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (fifoPop)
    );

    // ****************************************************************
    // Data-phase driver
    // ****************************************************************
    cbd_pkg::cbd_tx_state_t txState;
    logic                   busFree;

    assign busFree = (bus.occupiedN == `CBD_OFF);
    assign fifoPop = fifoOutValid
                   & (((txState == cbd_pkg::TX_IDLE) & dataGrant & busFree)
                   | (txState == cbd_pkg::TX_DRIVE));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txState <= cbd_pkg::TX_IDLE;
        end else begin
            unique case (txState)
                cbd_pkg::TX_IDLE: begin
                    if (fifoPop) begin
                        txState <= fifoOutData[`CBD_LAST_BIT] ? cbd_pkg::TX_END
                                                              : cbd_pkg::TX_DRIVE;
                    end
                end
                cbd_pkg::TX_DRIVE: begin
                    if (fifoPop && fifoOutData[`CBD_LAST_BIT]) begin
                        txState <= cbd_pkg::TX_END;
                    end
                end
                cbd_pkg::TX_END: begin
                    txState <= cbd_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.cpuOeN      <= `CBD_OFF;
            bus.cpuOccupied <= `CBD_OFF;
            bus.cpuStrobe   <= `CBD_OFF;
            bus.cpuData     <= `CBD_DATA_OFF;
            bus.cpuLanes    <= `CBD_LANE_OFF;
        end else begin
            if (fifoPop) begin
                bus.cpuOeN      <= `CBD_ON;
                bus.cpuOccupied <= `CBD_ON;
                bus.cpuStrobe   <= `CBD_ON;
                bus.cpuData     <= ~fifoOutData[63:0];
                bus.cpuLanes    <= eccEnabled ? ~cbd_pkg::cbd_check(fifoOutData[63:0])
                                              : `CBD_LANE_OFF;
            end else if (txState == cbd_pkg::TX_DRIVE) begin
                bus.cpuStrobe   <= `CBD_OFF;
            end else begin
                bus.cpuOeN      <= `CBD_OFF;
                bus.cpuOccupied <= `CBD_OFF;
                bus.cpuStrobe   <= `CBD_OFF;
            end
        end
    end

    // ****************************************************************
    // Receiver, deferral and float error
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxValid      <= 1'b0;
            rxData       <= `CBD_DATA_ZERO;
            rxCheckError <= 1'b0;
        end else begin
            // Own words are not echoed back to the user side
            rxValid <= (bus.strobeN == `CBD_ON) && bus.cpuOeN;
            if ((bus.strobeN == `CBD_ON) && bus.cpuOeN) begin
                rxData       <= ~bus.dataN;
                rxCheckError <= eccEnabled
                              && (cbd_pkg::cbd_check(~bus.dataN) != ~bus.lanesN);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            deferred        <= 1'b0;
            bus.floatErrorN <= `CBD_OFF;
        end else begin
            deferred        <= (bus.deferredN == `CBD_ON);
            bus.floatErrorN <= (fpError && !fpMasked) ? `CBD_ON : `CBD_OFF;
        end
    end
endmodule : cbd_cpu_end

// [verilog/cbd_defs.svh]
`ifndef CBD_DEFS_SVH
`define CBD_DEFS_SVH

// ****************************************************************
// Bus widths and FIFO shape
// ****************************************************************
`define CBD_DATA_W      64
`define CBD_LANE_W      8
`define CBD_FIFO_W      65
`define CBD_FIFO_DEPTH  8
`define CBD_LAST_BIT    64

// ****************************************************************
// Active-low line levels
// ****************************************************************
`define CBD_ON          1'b0
`define CBD_OFF         1'b1
`define CBD_DATA_OFF    64'hFFFF_FFFF_FFFF_FFFF
`define CBD_LANE_OFF    8'hFF
`define CBD_DATA_ZERO   64'h0000_0000_0000_0000
`define CBD_LANE_ZERO   8'h00

`endif

// [verilog/cbd_pkg.sv]
package cbd_pkg;

    typedef logic [63:0] cbd_word_t;
    typedef logic [7:0]  cbd_lane_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_DRIVE = 3'b010,
        TX_END   = 3'b100
    } cbd_tx_state_t;

    typedef enum logic [4:0] {
        FL_IDLE  = 5'b00001,
        FL_WB    = 5'b00010,
        FL_INVAL = 5'b00100,
        FL_ACK   = 5'b01000,
        FL_HOLD  = 5'b10000
    } cbd_flush_state_t;

    // One check lane per byte: even parity of that byte
    function automatic cbd_lane_t cbd_check(input cbd_word_t word);
        cbd_lane_t lanes;
        lanes = 8'h00;
        for (int i = 0; i < 8; i++) begin
            lanes[i] = ^word[i*8 +: 8];
        end
        return lanes;
    endfunction : cbd_check

endpackage : cbd_pkg

// [verilog/cbd_bus_if.sv]
`timescale 1ns/1ps
`include "cbd_defs.svh"
// ****************************************************************
// Shared bus wires; data, lane, strobe and occupied lines are wired-AND of both ends' drivers
// ****************************************************************
interface cbd_bus_if;
    logic [63:0] cpuData;
    logic [7:0]  cpuLanes;
    logic        cpuStrobe;
    logic        cpuOccupied;
    logic        cpuOeN;
    logic [63:0] agtData;
    logic [7:0]  agtLanes;
    logic        agtStrobe;
    logic        agtOccupied;
    logic        agtOeN;
    logic [63:0] dataN;
    logic [7:0]  lanesN;
    logic        strobeN;
    logic        occupiedN;
    logic        deferredN;
    logic        targetReadyN;
    logic        flushN;
    logic        floatErrorN;
    logic        flushAckN;

    assign dataN     = (cpuOeN ? `CBD_DATA_OFF : cpuData)
                     & (agtOeN ? `CBD_DATA_OFF : agtData);
    assign lanesN    = (cpuOeN ? `CBD_LANE_OFF : cpuLanes) & (agtOeN ? `CBD_LANE_OFF : agtLanes);
    assign strobeN   = (cpuOeN | cpuStrobe) & (agtOeN | agtStrobe);
    assign occupiedN = (cpuOeN | cpuOccupied) & (agtOeN | agtOccupied);

    modport cpu (
        output cpuData, cpuLanes, cpuStrobe, cpuOccupied, cpuOeN,
        output floatErrorN, flushAckN,
        input  dataN, lanesN, strobeN, occupiedN,
        input  deferredN, targetReadyN, flushN
    );
    modport agent (
        output agtData, agtLanes, agtStrobe, agtOccupied, agtOeN,
        output deferredN, targetReadyN, flushN,
        input  dataN, lanesN, strobeN, occupiedN,
        input  floatErrorN, flushAckN
    );
endinterface : cbd_bus_if

// [verilog/cbd_fifo.sv]
`timescale 1ns/1ps
module cbd_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cbd_fifo

// [verilog/cbd_agent_end.sv]
`timescale 1ns/1ps
`include "cbd_defs.svh"
module cbd_agent_end (
    input  wire logic        clk,
    input  wire logic        nrst,
    cbd_bus_if.agent         bus,
    input  wire logic        dataGrant,
    input  wire logic        eccOn,
    input  wire logic        txValid,
    input  wire logic [63:0] txData,
    input  wire logic        txLast,
    output logic             txReady,
    output logic             rxValid,
    output logic      [63:0] rxData,
    output logic             rxCheckError,
    input  wire logic        deferReq,
    input  wire logic        targetReady,
    input  wire logic        flushReq,
    output logic             floatError,
    output logic             flushAck
);
    // ****************************************************************
    // Data-phase driver
    // ****************************************************************
    cbd_pkg::cbd_tx_state_t txState;
    logic                   take;

    // Words are taken straight from the user; a gap in txValid is an idle clock
    assign take    = txValid & ((txState == cbd_pkg::TX_DRIVE)
                   | ((txState == cbd_pkg::TX_IDLE) & dataGrant
                   & (bus.occupiedN == `CBD_OFF)));
    assign txReady = take;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txState <= cbd_pkg::TX_IDLE;
        end else begin
            unique case (txState)
                cbd_pkg::TX_IDLE: begin
                    if (take) begin
                        txState <= txLast ? cbd_pkg::TX_END : cbd_pkg::TX_DRIVE;
                    end
                end
                cbd_pkg::TX_DRIVE: begin
                    if (take && txLast) begin
                        txState <= cbd_pkg::TX_END;
                    end
                end
                cbd_pkg::TX_END: begin
                    txState <= cbd_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.agtOeN      <= `CBD_OFF;
            bus.agtOccupied <= `CBD_OFF;
            bus.agtStrobe   <= `CBD_OFF;
            bus.agtData     <= `CBD_DATA_OFF;
            bus.agtLanes    <= `CBD_LANE_OFF;
        end else begin
            if (take) begin
                bus.agtOeN      <= `CBD_ON;
                bus.agtOccupied <= `CBD_ON;
                bus.agtStrobe   <= `CBD_ON;
                bus.agtData     <= ~txData;
                bus.agtLanes    <= eccOn ? ~cbd_pkg::cbd_check(txData) : `CBD_LANE_OFF;
            end else if (txState == cbd_pkg::TX_DRIVE) begin
                bus.agtStrobe   <= `CBD_OFF;
            end else begin
                bus.agtOeN      <= `CBD_OFF;
                bus.agtOccupied <= `CBD_OFF;
                bus.agtStrobe   <= `CBD_OFF;
            end
        end
    end

    // ****************************************************************
    // Receiver and system-side control lines
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxValid      <= 1'b0;
            rxData       <= `CBD_DATA_ZERO;
            rxCheckError <= 1'b0;
        end else begin
            rxValid <= (bus.strobeN == `CBD_ON) && bus.agtOeN;
            if ((bus.strobeN == `CBD_ON) && bus.agtOeN) begin
                rxData       <= ~bus.dataN;
                rxCheckError <= eccOn && (cbd_pkg::cbd_check(~bus.dataN) != ~bus.lanesN);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.deferredN    <= `CBD_OFF;
            bus.targetReadyN <= `CBD_OFF;
            floatError       <= 1'b0;
            flushAck         <= 1'b0;
        end else begin
            bus.deferredN    <= deferReq ? `CBD_ON : `CBD_OFF;
            bus.targetReadyN <= targetReady ? `CBD_ON : `CBD_OFF;
            floatError       <= (bus.floatErrorN == `CBD_ON);
            flushAck         <= (bus.flushAckN == `CBD_ON);
        end
    end

    // Not reset: the pin level must reach the strap sampler while reset is held
    always_ff @(posedge clk) begin
        bus.flushN <= flushReq ? `CBD_ON : `CBD_OFF;
    end
endmodule : cbd_agent_end

// [verification/cbd_bus_monitor.sv]
`timescale 1ns/1ps
module cbd_bus_monitor #(
    parameter bit ECC_ON = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        cpuOeN,
    input  wire logic        agtOeN,
    input  wire logic [63:0] dataN,
    input  wire logic [7:0]  lanesN,
    input  wire logic        strobeN,
    input  wire logic        occupiedN,
    input  wire logic        flushAckN
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Inverting a byte keeps its parity, so the bus word gives the lane directly
    function automatic logic [7:0] lane_of(input logic [63:0] w);
        logic [7:0] p;
        for (int i = 0; i < 8; i++) begin
            p[i] = ^w[i*8 +: 8];
        end
        return ~p;
    endfunction : lane_of

    // ****************************************************************
    // Data phase
    // ****************************************************************
    a_one_data_driver: assert property (!(!cpuOeN && !agtOeN))
        else $error("both ends drive the data bus");
    a_start_when_free: assert property ($fell(cpuOeN) || $fell(agtOeN) |-> $past(occupiedN))
        else $error("data bus taken while still occupied");
    a_busy_with_drive: assert property (!cpuOeN || !agtOeN |-> !occupiedN)
        else $error("driver on bus without occupied");
    a_release_after_word: assert property ($rose(cpuOeN) || $rose(agtOeN) |-> $past(!strobeN))
        else $error("release not right after last word");
    a_idle_lines_high: assert property (cpuOeN && agtOeN |-> strobeN && occupiedN
        && dataN == 64'hFFFF_FFFF_FFFF_FFFF && lanesN == 8'hFF)
        else $error("released bus not at inactive level");
    a_lanes_match_data: assert property (!strobeN |->
        lanesN == (ECC_ON ? lane_of(dataN) : 8'hFF))
        else $error("check lanes do not match data word");

    // ****************************************************************
    // Flush acknowledge
    // ****************************************************************
    a_ack_single_pulse: assert property (!flushAckN |=> flushAckN)
        else $error("flush acknowledge longer than one cycle");
    a_ack_cpu_quiet: assert property ($fell(flushAckN) |-> cpuOeN && $past(cpuOeN, 2))
        else $error("flush acknowledge during write back");

    c_cpu_word: cover property (!cpuOeN && !strobeN);
    c_agent_word: cover property (!agtOeN && !strobeN);
    c_flush_ack: cover property ($fell(flushAckN));
    c_idle_gap: cover property (!cpuOeN && strobeN);
endmodule : cbd_bus_monitor

// [verification/cpu_bus_data_phase_flush_bench.sv]
`timescale 1ns/1ps
module cpu_bus_data_phase_flush_bench;
    logic        clk, nrst, gntC, gntA, eccStrap, eccOn;
    logic        txValidC, txLastC, txReadyC, rxValidC, rxErrC, deferred;
    logic        txValidA, txLastA, txReadyA, rxValidA, rxErrA;
    logic        fpError, fpMasked, dirtyValid, dirtyLast, dirtyDone, dirtyReady;
    logic        invalidateAll, noAllocate, flushBusy, eccEnabled, flushStrap;
    logic        deferReq, targetReady, flushReq, floatError, flushAck;
    logic [63:0] txDataC, rxDataC, txDataA, rxDataA, dirtyData;
    logic [64:0] rxA[$];
    logic [64:0] rxC[$];
    int          error_cnt, checked, cycles;

    cbd_bus_if bus();
    cbd_cpu_end i_cbd_cpu_end (.clk(clk), .nrst(nrst), .bus(bus), .dataGrant(gntC),
        .eccStrap(eccStrap), .txValid(txValidC), .txData(txDataC), .txLast(txLastC),
        .txReady(txReadyC), .rxValid(rxValidC), .rxData(rxDataC), .rxCheckError(rxErrC),
        .deferred(deferred), .fpError(fpError), .fpMasked(fpMasked),
        .dirtyValid(dirtyValid), .dirtyData(dirtyData), .dirtyLast(dirtyLast),
        .dirtyDone(dirtyDone), .dirtyReady(dirtyReady), .invalidateAll(invalidateAll),
        .noAllocate(noAllocate), .flushBusy(flushBusy), .eccEnabled(eccEnabled),
        .flushStrap(flushStrap));
    cbd_agent_end i_cbd_agent_end (.clk(clk), .nrst(nrst), .bus(bus), .dataGrant(gntA),
        .eccOn(eccOn), .txValid(txValidA), .txData(txDataA), .txLast(txLastA),
        .txReady(txReadyA), .rxValid(rxValidA), .rxData(rxDataA), .rxCheckError(rxErrA),
        .deferReq(deferReq), .targetReady(targetReady), .flushReq(flushReq),
        .floatError(floatError), .flushAck(flushAck));
    cbd_bus_monitor i_cbd_bus_monitor (.clk(clk), .nrst(nrst), .cpuOeN(bus.cpuOeN),
        .agtOeN(bus.agtOeN), .dataN(bus.dataN), .lanesN(bus.lanesN),
        .strobeN(bus.strobeN), .occupiedN(bus.occupiedN), .flushAckN(bus.flushAckN));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************************************
    // Capture and checking helpers
    // ****************************************************************
    always @(posedge clk) begin
        if (rxValidA === 1'b1) rxA.push_back({rxErrA, rxDataA});
        if (rxValidC === 1'b1) rxC.push_back({rxErrC, rxDataC});
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic cmp(input string what, input logic [64:0] exp, input logic [64:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    function automatic logic [63:0] word(input logic [63:0] base, input int i);
        return base ^ {8{8'(i * 37)}};
    endfunction : word

    function automatic logic sig(input int s);
        case (s)
            0: return txReadyC;
            1: return txReadyA;
            2: return dirtyReady;
            3: return invalidateAll;
            4: return flushAck;
            5: return flushBusy;
            6: return floatError;
            default: return deferred;
        endcase
    endfunction : sig

    // Polls at falling edges, where registered outputs have settled
    task automatic wait_hi(input int s, input int lim, input string what);
        for (int k = 0; k < lim && sig(s) !== 1'b1; k++) begin
            @(negedge clk);
        end
        cmp(what, 65'h1, {64'h0, sig(s)});
    endtask : wait_hi

    // Stream driver: request held from a falling edge until a rising edge with ready
    task automatic send(input int sel, input int n, input logic [63:0] base,
                        input bit gap = 1'b0);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            // One idle clock before the second word, to open a gap on the bus
            if (gap && i == 1) begin
                {txValidC, txValidA, dirtyValid} = 3'b000;
                @(negedge clk);
            end
            case (sel)
                0: {txValidC, txDataC, txLastC} = {1'b1, word(base, i), i == n - 1};
                1: {txValidA, txDataA, txLastA} = {1'b1, word(base, i), i == n - 1};
                default: {dirtyValid, dirtyData, dirtyLast} = {1'b1, word(base, i), i == n - 1};
            endcase
            for (int k = 0; k < 200; k++) begin
                @(posedge clk);
                if (sig(sel) === 1'b1) break;
            end
        end
        @(negedge clk);
        txValidC = 1'b0;
        txValidA = 1'b0;
        dirtyValid = 1'b0;
    endtask : send

    task automatic rx_check(input bit toCpu, input int n, input logic [63:0] base);
        logic [64:0] got;
        for (int k = 0; k < 100 && (toCpu ? rxC.size() : rxA.size()) < n; k++) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            got = toCpu ? rxC.pop_front() : rxA.pop_front();
            cmp("rx word", {1'b0, word(base, i)}, got);
        end
    endtask : rx_check

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        {nrst, gntC, gntA, txValidC, txLastC, txValidA, txLastA, fpError, fpMasked} = 9'h000;
        {dirtyValid, dirtyLast, dirtyDone, deferReq, targetReady, flushReq} = 6'h00;
        {txDataC, txDataA, dirtyData} = {3{64'h0000_0000_0000_0000}};
        eccStrap = 1'b1;
        eccOn = 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        cmp("eccEnabled", 65'h1, {64'h0, eccEnabled});
        cmp("flushStrap", 65'h0, {64'h0, flushStrap});
        eccStrap = 1'b0;
        send(0, 8, 64'h0123_4567_89AB_CDEF);
        cmp("txReady full", 65'h0, {64'h0, txReadyC});
        gntC = 1'b1;
        rx_check(1'b0, 8, 64'h0123_4567_89AB_CDEF);
        send(0, 3, 64'hF0F0_1234_0000_FFFF, 1'b1);
        rx_check(1'b0, 3, 64'hF0F0_1234_0000_FFFF);
        gntC = 1'b0;
        gntA = 1'b1;
        send(1, 5, 64'h8000_0000_0000_0001);
        rx_check(1'b1, 5, 64'h8000_0000_0000_0001);
        gntA = 1'b0;
        fpError = 1'b1;
        fpMasked = 1'b1;
        repeat (4) @(negedge clk);
        cmp("floatError masked", 65'h0, {64'h0, floatError});
        fpMasked = 1'b0;
        wait_hi(6, 2, "floatError");
        deferReq = 1'b1;
        wait_hi(7, 2, "deferred");
        gntC = 1'b1;
        flushReq = 1'b1;
        wait_hi(5, 6, "flushBusy");
        cmp("noAllocate", 65'h1, {64'h0, noAllocate});
        cmp("txReady in flush", 65'h0, {64'h0, txReadyC});
        send(2, 4, 64'h5555_AAAA_3333_CCCC);
        dirtyDone = 1'b1;
        rx_check(1'b0, 4, 64'h5555_AAAA_3333_CCCC);
        wait_hi(3, 20, "invalidateAll");
        wait_hi(4, 3, "flushAck");
        cmp("noAllocate held", 65'h1, {64'h0, noAllocate});
        cmp("eccEnabled held", 65'h1, {64'h0, eccEnabled});
        @(negedge clk);
        flushReq = 1'b0;
        dirtyDone = 1'b0;
        repeat (8) @(negedge clk);
        cmp("noAllocate off", 65'h0, {64'h0, noAllocate});
        cmp("flushBusy off", 65'h0, {64'h0, flushBusy});
        // Mid-run reset with the flush pin held: the strap must catch it
        flushReq = 1'b1;
        nrst = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        cmp("flushStrap set", 65'h1, {64'h0, flushStrap});
        cmp("eccEnabled off", 65'h0, {64'h0, eccEnabled});
        test_done();
    end
endmodule : cpu_bus_data_phase_flush_bench
